// ==== verilog/ssm_setting_menu.sv ====
// Function
// - teach window hold: steady LED, teach armed
// - release in teach window: start, fast blink
// - teach result: two or four slow blinks
// - ten to fifteen seconds: blink, material select
// - each press toggles paper and metal
// - colour shows type: green paper, red metal
// - material and offset leave after ten seconds
// - offset window release: blink current offset
// - default offset six paper, ten metal
// - short press increments, long press decrements
// - blink new offset after every change
// - offset stays within one through twenty
// - over twenty seconds restores factory setting
// - factory restore confirmed by two blinks
// - hold counter cleared when function ends
//
// The register addresses and the strobed register port are this design's own decisions.
module ssm_setting_menu
    import ssm_pkg::*;
#(
    parameter int TICK_CYCLES = TICK_CYC
) (
    // clock and reset
    input wire logic clock,
    input wire logic rstn,
    // operator button, pressed low
    input wire logic buttonN,
    // sensing logic
    input wire logic teachDone,
    input wire logic teachPass,
    output logic teachStart,
    output logic teachBusy,
    output logic labelMetal,
    output logic [4:0] offsetVal,
    // two colour lamp
    output logic ledGreen,
    output logic ledRed,
    // register port
    input wire logic [ADDR_W-1:0] regAddr,
    input wire logic [31:0] regWdata,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [31:0] regRdata,
    output logic irq
);

    localparam int TW = $clog2(TICK_CYCLES);

    ssm_blink_if bl();

    ssm_blinker u_blinker (
        .clock(clock),
        .rstn(rstn),
        .bus(bl.blinker)
    );

    logic [TW-1:0] tickCnt_r;
    logic tick_r;
    logic btnMeta_r;
    logic btnSync_r;
    logic btnStable_r;
    logic [TK_W-1:0] debCnt_r;
    logic pressEdge;
    logic releaseEdge;
    logic pressed;
    ssm_state_t state_r;
    logic [TK_W-1:0] holdCnt_r;
    logic [TK_W-1:0] idleCnt_r;
    logic [TK_W-1:0] teachCnt_r;
    logic [PHASE_W-1:0] phase_r;
    logic metal_r;
    logic [4:0] offset_r;
    logic [4:0] ofsNext;
    logic teachStart_r;
    logic blinkStart_r;
    logic [4:0] blinkCount_r;
    logic codeRed_r;
    logic [EV_W-1:0] evt_r;
    logic lock_r;
    logic [EV_W-1:0] irqStat_r;
    logic [EV_W-1:0] irqMask_r;
    logic [31:0] rdata_r;
    logic ledGreen_r;
    logic ledRed_r;
    logic lampOn;
    logic lampRed;
    logic timeout;
    ssm_info_t info;

    assign bl.tick = tick_r;
    assign bl.start = blinkStart_r;
    assign bl.count = blinkCount_r;

    assign teachStart = teachStart_r;
    assign teachBusy = (state_r == ST_TEACH);
    assign labelMetal = metal_r;
    assign offsetVal = offset_r;
    assign ledGreen = ledGreen_r;
    assign ledRed = ledRed_r;
    assign regRdata = rdata_r;
    assign irq = |(irqStat_r & irqMask_r);

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            tickCnt_r <= '0;
            tick_r <= 1'b0;
        end else begin
            tick_r <= (tickCnt_r == TW'(TICK_CYCLES - 1));
            if (tickCnt_r == TW'(TICK_CYCLES - 1)) begin
                tickCnt_r <= '0;
            end else begin
                tickCnt_r <= tickCnt_r + 1'b1;
            end
        end
    end

    // pin synchroniser, two stages before any logic
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            btnMeta_r <= 1'b0;
            btnSync_r <= 1'b0;
        end else begin
            btnMeta_r <= ~buttonN;
            btnSync_r <= btnMeta_r;
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            btnStable_r <= 1'b0;
            debCnt_r <= '0;
        end else if (btnSync_r == btnStable_r) begin
            debCnt_r <= '0;
        end else if (tick_r) begin
            if (debCnt_r >= DEB_TK - 1'b1) begin
                btnStable_r <= btnSync_r;
                debCnt_r <= '0;
            end else begin
                debCnt_r <= debCnt_r + 1'b1;
            end
        end
    end

    // edges seen with the debounced level; at most one per cycle
    assign pressEdge = btnSync_r && !btnStable_r && tick_r && (debCnt_r >= DEB_TK - 1'b1)
        && !lock_r;
    assign releaseEdge = !btnSync_r && btnStable_r && tick_r && (debCnt_r >= DEB_TK - 1'b1)
        && !lock_r;
    assign pressed = btnStable_r && !lock_r;

    // hold counter, cleared outside a measured press
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            holdCnt_r <= '0;
        end else if ((state_r != ST_HOLD && state_r != ST_OFS) || pressEdge) begin
            holdCnt_r <= '0;
        end else if (tick_r && pressed && holdCnt_r < FACT_TK) begin
            holdCnt_r <= holdCnt_r + 1'b1; // saturates, no wrap on long holds
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            idleCnt_r <= '0;
        end else if ((state_r != ST_MAT && state_r != ST_OFS) || pressed) begin
            idleCnt_r <= '0;
        end else if (tick_r && idleCnt_r < IDLE_TK) begin
            idleCnt_r <= idleCnt_r + 1'b1;
        end
    end
    assign timeout = (idleCnt_r == IDLE_TK);

    // guard against a sensing side that never answers
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            teachCnt_r <= '0;
        end else if (state_r != ST_TEACH) begin
            teachCnt_r <= '0;
        end else if (tick_r && teachCnt_r < TEACH_MAX_TK) begin
            teachCnt_r <= teachCnt_r + 1'b1;
        end
    end

    // free blink phase for steady blinking
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            phase_r <= '0;
        end else if (tick_r) begin
            phase_r <= phase_r + 1'b1;
        end
    end

    // next offset, clamped at both ends
    always_comb begin
        ofsNext = offset_r;
        if (holdCnt_r < DEC_TK) begin
            if (offset_r < OFS_MAX) begin
                ofsNext = offset_r + 5'h01;
            end
        end else if (offset_r > OFS_MIN) begin
            ofsNext = offset_r - 5'h01;
        end
    end

    // menu sequence and stored settings
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            state_r <= ST_IDLE;
            metal_r <= LABEL_RST;
            offset_r <= OFS_PAPER;
            teachStart_r <= 1'b0;
            blinkStart_r <= 1'b0;
            blinkCount_r <= 5'h00;
            codeRed_r <= 1'b0;
            evt_r <= '0;
        end else begin
            teachStart_r <= 1'b0;
            blinkStart_r <= 1'b0;
            evt_r <= '0;
            case (state_r)
                ST_IDLE: begin
                    if (pressEdge) begin
                        state_r <= ST_HOLD;
                    end
                end
                ST_HOLD: begin
                    if (releaseEdge) begin
                        codeRed_r <= 1'b0;
                        if (holdCnt_r < TEACH_TK) begin
                            state_r <= ST_IDLE;
                        end else if (holdCnt_r < MAT_TK) begin
                            state_r <= ST_TEACH;
                            teachStart_r <= 1'b1;
                        end else if (holdCnt_r < OFS_TK) begin
                            state_r <= ST_MAT;
                        end else if (holdCnt_r < FACT_TK) begin
                            state_r <= ST_OFS;
                            blinkStart_r <= 1'b1;
                            blinkCount_r <= offset_r;
                        end else begin
                            metal_r <= LABEL_RST;
                            offset_r <= OFS_PAPER;
                            blinkStart_r <= 1'b1;
                            blinkCount_r <= CODE_OK;
                            evt_r[EV_FACTORY] <= 1'b1;
                            state_r <= ST_SHOW;
                        end
                    end
                end
                ST_TEACH: begin
                    if (teachDone || teachCnt_r == TEACH_MAX_TK) begin
                        blinkStart_r <= 1'b1;
                        blinkCount_r <= (teachDone && teachPass) ? CODE_OK : CODE_FAIL;
                        codeRed_r <= !(teachDone && teachPass);
                        evt_r[EV_TEACH_OK] <= teachDone && teachPass;
                        evt_r[EV_TEACH_FAIL] <= !(teachDone && teachPass);
                        state_r <= ST_SHOW;
                    end
                end
                ST_MAT: begin
                    if (timeout) begin
                        evt_r[EV_TIMEOUT] <= 1'b1;
                        state_r <= ST_IDLE;
                    end else if (pressEdge) begin
                        metal_r <= !metal_r;
                        offset_r <= metal_r ? OFS_PAPER : OFS_METAL;
                        evt_r[EV_MATERIAL] <= 1'b1;
                    end
                end
                ST_OFS: begin
                    if (timeout) begin
                        evt_r[EV_TIMEOUT] <= 1'b1;
                        state_r <= ST_IDLE;
                    end else if (releaseEdge) begin
                        offset_r <= ofsNext;
                        blinkStart_r <= 1'b1;
                        blinkCount_r <= ofsNext;
                        evt_r[EV_OFFSET] <= 1'b1;
                    end
                end
                ST_SHOW: begin
                    // busy rises one cycle after the start pulse
                    if (!bl.busy && !blinkStart_r) begin
                        state_r <= ST_IDLE;
                    end
                end
                default: begin
                    state_r <= ST_IDLE;
                end
            endcase
        end
    end

    // lamp pattern per state and hold window
    always_comb begin
        lampOn = 1'b0;
        lampRed = 1'b0;
        case (state_r)
            ST_HOLD: begin
                // steady in teach and factory windows
                if (holdCnt_r >= TEACH_TK && holdCnt_r < MAT_TK) begin
                    lampOn = 1'b1;
                end else if (holdCnt_r >= MAT_TK && holdCnt_r < OFS_TK) begin
                    lampOn = phase_r[SLOW_BIT];
                end else if (holdCnt_r >= FACT_TK) begin
                    lampOn = 1'b1;
                end
            end
            ST_TEACH: begin
                lampOn = phase_r[FAST_BIT];
            end
            ST_MAT: begin
                lampOn = phase_r[SLOW_BIT];
                lampRed = metal_r;
            end
            ST_OFS, ST_SHOW: begin
                lampOn = bl.lamp;
                lampRed = codeRed_r;
            end
            default: begin
                lampOn = 1'b0;
            end
        endcase
    end

    // lamp drivers from flops
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            ledGreen_r <= 1'b0;
            ledRed_r <= 1'b0;
        end else begin
            ledGreen_r <= lampOn && !lampRed;
            ledRed_r <= lampOn && lampRed;
        end
    end

    // control and mask registers
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            lock_r <= 1'b0;
            irqMask_r <= '0;
        end else if (regWrite) begin
            if (regAddr == REG_CTRL) begin
                lock_r <= regWdata[CTRL_LOCK_BIT];
            end
            if (regAddr == REG_IRQ_MASK) begin
                irqMask_r <= regWdata[EV_W-1:0];
            end
        end
    end

    // sticky events; a new event beats a same-cycle clear
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            irqStat_r <= '0;
        end else if (regWrite && regAddr == REG_IRQ_STAT) begin
            irqStat_r <= (irqStat_r & ~regWdata[EV_W-1:0]) | evt_r;
        end else begin
            irqStat_r <= irqStat_r | evt_r;
        end
    end

    // info view of the menu
    always_comb begin
        info = '0;
        info.state = state_r;
        info.metal = metal_r;
        info.offset = offset_r;
    end

    // read data one cycle after the strobe, zero otherwise
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            rdata_r <= 32'h0000_0000;
        end else if (regRead) begin
            case (regAddr)
                REG_INFO: rdata_r <= info;
                REG_CTRL: rdata_r <= {31'h0000_0000, lock_r};
                REG_IRQ_STAT: rdata_r <= {26'h000_0000, irqStat_r};
                REG_IRQ_MASK: rdata_r <= {26'h000_0000, irqMask_r};
                default: rdata_r <= 32'h0000_0000;
            endcase
        end else begin
            rdata_r <= 32'h0000_0000;
        end
    end

endmodule : ssm_setting_menu

// ==== verilog/ssm_pkg.sv ====
package ssm_pkg;

    // clock and timebase
    localparam int CLK_HZ = 20_000_000;
    localparam int TICK_MS = 10;
    localparam int TICK_CYC = CLK_HZ / 1000 * TICK_MS;

    // hold and timeout figures, seconds
    localparam int T_TEACH_S = 2;
    localparam int T_MAT_S = 10;
    localparam int T_OFS_S = 15;
    localparam int T_FACT_S = 20;
    localparam int T_IDLE_S = 10;
    localparam int T_DEC_S = 2;
    localparam int T_TEACH_MAX_S = 10;
    // shorter figures, milliseconds
    localparam int T_DEB_MS = 20;
    localparam int T_SLOW_HALF_MS = 250;

    // the same figures as counts of ticks
    localparam int TK_W = 12;
    localparam logic [TK_W-1:0] TEACH_TK = TK_W'(T_TEACH_S * 1000 / TICK_MS);
    localparam logic [TK_W-1:0] MAT_TK = TK_W'(T_MAT_S * 1000 / TICK_MS);
    localparam logic [TK_W-1:0] OFS_TK = TK_W'(T_OFS_S * 1000 / TICK_MS);
    localparam logic [TK_W-1:0] FACT_TK = TK_W'(T_FACT_S * 1000 / TICK_MS);
    localparam logic [TK_W-1:0] IDLE_TK = TK_W'(T_IDLE_S * 1000 / TICK_MS);
    localparam logic [TK_W-1:0] DEC_TK = TK_W'(T_DEC_S * 1000 / TICK_MS);
    localparam logic [TK_W-1:0] TEACH_MAX_TK = TK_W'(T_TEACH_MAX_S * 1000 / TICK_MS);
    localparam logic [TK_W-1:0] DEB_TK = TK_W'(T_DEB_MS / TICK_MS);
    localparam logic [TK_W-1:0] SLOW_HALF_TK = TK_W'(T_SLOW_HALF_MS / TICK_MS);

    // free blink phase: bit positions of a tick counter
    localparam int PHASE_W = 8;
    localparam int FAST_BIT = 2;
    localparam int SLOW_BIT = 4;

    // offset range and defaults
    localparam logic [4:0] OFS_MIN = 5'h01;
    localparam logic [4:0] OFS_MAX = 5'h14;
    localparam logic [4:0] OFS_PAPER = 5'h06;
    localparam logic [4:0] OFS_METAL = 5'h0a;
    localparam logic LABEL_RST = 1'b0;

    // blink code counts
    localparam logic [4:0] CODE_OK = 5'h02;
    localparam logic [4:0] CODE_FAIL = 5'h04;

    // register map, word offsets
    localparam int ADDR_W = 4;
    localparam logic [ADDR_W-1:0] REG_INFO = 4'h0;
    localparam logic [ADDR_W-1:0] REG_CTRL = 4'h1;
    localparam logic [ADDR_W-1:0] REG_IRQ_STAT = 4'h2;
    localparam logic [ADDR_W-1:0] REG_IRQ_MASK = 4'h3;
    localparam int CTRL_LOCK_BIT = 0;

    // event bits of status and mask
    localparam int EV_W = 6;
    localparam int EV_TEACH_OK = 0;
    localparam int EV_TEACH_FAIL = 1;
    localparam int EV_MATERIAL = 2;
    localparam int EV_OFFSET = 3;
    localparam int EV_FACTORY = 4;
    localparam int EV_TIMEOUT = 5;

    typedef enum logic [5:0] {
        ST_IDLE = 6'h01,
        ST_HOLD = 6'h02,
        ST_TEACH = 6'h04,
        ST_MAT = 6'h08,
        ST_OFS = 6'h10,
        ST_SHOW = 6'h20
    } ssm_state_t;

    // read layout of the info register
    typedef struct packed {
        logic [15:0] rsvdHi;
        logic [1:0] rsvdMid;
        ssm_state_t state;
        logic [1:0] rsvdLo;
        logic metal;
        logic [4:0] offset;
    } ssm_info_t;

endpackage : ssm_pkg

// ==== verilog/ssm_blink_if.sv ====
interface ssm_blink_if;
    logic tick;
    logic start;
    logic [4:0] count;
    logic busy;
    logic lamp;

    modport menu (output tick, output start, output count, input busy, input lamp);
    modport blinker (input tick, input start, input count, output busy, output lamp);
endinterface : ssm_blink_if

// ==== verilog/ssm_blinker.sv ====
module ssm_blinker
    import ssm_pkg::*;
(
    // clock and reset
    input wire logic clock,
    input wire logic rstn,
    // sequence request and lamp
    ssm_blink_if.blinker bus
);

    logic [4:0] remain_r;
    logic [TK_W-1:0] halfCnt_r;
    logic busy_r;
    logic lamp_r;

    assign bus.busy = busy_r;
    assign bus.lamp = lamp_r;

    // slow counted blinks: on half, off half, repeated count times
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            remain_r <= 5'h00;
            halfCnt_r <= '0;
            busy_r <= 1'b0;
            lamp_r <= 1'b0;
        end else if (bus.start) begin
            // a new request cuts any running sequence short
            remain_r <= bus.count;
            halfCnt_r <= '0;
            busy_r <= (bus.count != 5'h00);
            lamp_r <= 1'b0;
        end else if (busy_r && bus.tick) begin
            if (halfCnt_r == SLOW_HALF_TK - 1'b1) begin
                halfCnt_r <= '0;
                if (lamp_r) begin
                    lamp_r <= 1'b0;
                    remain_r <= remain_r - 5'h01;
                end else if (remain_r == 5'h00) begin
                    busy_r <= 1'b0; // trailing dark half ends the code
                end else begin
                    lamp_r <= 1'b1;
                end
            end else begin
                halfCnt_r <= halfCnt_r + 1'b1;
            end
        end
    end

endmodule : ssm_blinker

// ==== testbench/ssm_menu_props.sv ====
module ssm_menu_props
    import ssm_pkg::*;
(
    // clock and reset
    input wire logic clock,
    input wire logic rstn,
    // watched outputs
    input wire logic teachStart,
    input wire logic teachBusy,
    input wire logic labelMetal,
    input wire logic [4:0] offsetVal,
    input wire logic ledGreen,
    input wire logic ledRed,
    // register port
    input wire logic regRead,
    input wire logic [31:0] regRdata
);
    timeunit 1ns;
    timeprecision 1ns;
    // first half of a code is dark
    localparam int CODE_WAIT = 200;
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstn);

    chk_single_colour: assert property (!(ledGreen && ledRed))
        else $error("both lamp colours lit");
    chk_offset_range: assert property (offsetVal >= OFS_MIN && offsetVal <= OFS_MAX)
        else $error("offset outside its range");
    chk_start_pulse: assert property (teachStart |=> !teachStart)
        else $error("teach start longer than one cycle");
    chk_start_busy: assert property (teachStart |-> ##[0:2] teachBusy)
        else $error("teach start without teach state");
    chk_offset_step: assert property ($changed(offsetVal) |-> $changed(labelMetal)
        || labelMetal != $past(labelMetal, 2) || offsetVal == $past(offsetVal) + 5'h01
        || offsetVal == $past(offsetVal) - 5'h01 || offsetVal == OFS_PAPER)
        else $error("offset jumped by more than one");
    chk_type_default: assert property ($changed(labelMetal) |-> ##[0:1]
        offsetVal == (labelMetal ? OFS_METAL : OFS_PAPER))
        else $error("type change without its default offset");
    // read data only after a read
    chk_rdata_quiet: assert property (!$past(regRead) |-> regRdata == 32'h0)
        else $error("read data outside its cycle");
    chk_code_follows: assert property ($fell(teachBusy) |-> ##[1:CODE_WAIT]
        (ledGreen || ledRed))
        else $error("no code after teach");

    // main scenarios
    cov_teach: cover property (teachStart);
    cov_metal: cover property ($rose(labelMetal));
    cov_top: cover property (offsetVal == OFS_MAX);
endmodule : ssm_menu_props

// ==== testbench/ssm_operator.sv ====
module ssm_operator #(
    parameter int TK = 4
) (
    // clock
    input wire logic clock,
    // button pin, pressed low, pulled up
    output logic buttonN
);
    timeunit 1ns;
    timeprecision 1ns;
    initial buttonN = 1'b1;

    // contact chatter on each edge, shorter than the debounce span
    task automatic chatter(input logic lvl);
        @(posedge clock) buttonN <= lvl;
        @(posedge clock) buttonN <= !lvl;
        @(posedge clock) buttonN <= lvl;
    endtask : chatter

    // hold for a number of ticks, return once the release has settled
    task automatic press(input int ticks);
        chatter(1'b0);
        repeat (ticks * TK) @(posedge clock);
        chatter(1'b1);
        repeat (3 * TK) @(posedge clock);
    endtask : press
endmodule : ssm_operator

// ==== testbench/ssm_setting_menu_tb.sv ====
module ssm_setting_menu_tb
    import ssm_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    // short tick keeps the run brief; waits other than reset and register access are in ticks
    localparam int TK = 4;
    logic clock = 1'b0;
    logic rstn = 1'b0;
    logic buttonN;
    logic teachDone = 1'b0;
    logic teachPass = 1'b0;
    logic teachStart, teachBusy, labelMetal, ledGreen, ledRed, irq;
    logic [4:0] offsetVal, ofs;
    logic [ADDR_W-1:0] regAddr = 4'h0;
    logic [31:0] regWdata = 32'h0;
    logic regWrite = 1'b0;
    logic regRead = 1'b0;
    logic [31:0] regRdata, rd;
    int errors = 0;
    int check_count = 0;
    int starts = 0;
    int gl, rl, ge, re, n, s0;

    // 20 MHz clock
    initial forever #25 clock = ~clock;

    ssm_operator #(.TK(TK)) i_ssm_operator (.clock(clock), .buttonN(buttonN));
    ssm_setting_menu #(.TICK_CYCLES(TK)) i_ssm_setting_menu (.clock(clock), .rstn(rstn),
        .buttonN(buttonN), .teachDone(teachDone), .teachPass(teachPass),
        .teachStart(teachStart), .teachBusy(teachBusy), .labelMetal(labelMetal),
        .offsetVal(offsetVal), .ledGreen(ledGreen), .ledRed(ledRed), .regAddr(regAddr),
        .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead),
        .regRdata(regRdata), .irq(irq));

    // count teach start pulses
    always @(posedge clock) if (teachStart === 1'b1) starts <= starts + 1;

    function automatic logic [31:0] exp_info(input logic [4:0] o, input logic m,
        input ssm_state_t s);
        return {18'h0, s, 2'h0, m, o};
    endfunction : exp_info

    // clamped step, up or down
    function automatic logic [4:0] step(input logic [4:0] o, input logic up);
        if (up) return (o == OFS_MAX) ? o : o + 5'h01;
        return (o == OFS_MIN) ? o : o - 5'h01;
    endfunction : step

    function automatic logic [31:0] lamp();
        return {30'h0, ledGreen, ledRed};
    endfunction : lamp

    task automatic give_verdict();
        if (errors == 0 && check_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : give_verdict

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            errors++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
        @(posedge clock);
        regAddr <= a;
        regWdata <= d;
        regWrite <= 1'b1;
        @(posedge clock);
        regWrite <= 1'b0;
        #1;
    endtask : wr

    task automatic reg_rd(input logic [ADDR_W-1:0] a, output logic [31:0] d);
        @(posedge clock);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge clock);
        regRead <= 1'b0;
        #1;
        d = regRdata;
    endtask : reg_rd

    task automatic chk_info(input logic [4:0] o, input logic m, input ssm_state_t s);
        reg_rd(REG_INFO, rd);
        check("info", exp_info(o, m, s), rd);
    endtask : chk_info

    task automatic tick_wait(input int t);
        repeat (t * TK) @(posedge clock);
        #1;
    endtask : tick_wait

    // long pulses (slow code blinks) and rising edges of each colour
    task automatic watch(input int t);
        int gn = 0;
        int rn = 0;
        logic gp = ledGreen;
        logic rp = ledRed;
        gl = 0; rl = 0; ge = 0; re = 0;
        repeat (t * TK) begin
            @(posedge clock);
            #1;
            if (ledGreen === 1'b1) gn++; else begin if (gn >= 20 * TK) gl++; gn = 0; end
            if (ledRed === 1'b1) rn++; else begin if (rn >= 20 * TK) rl++; rn = 0; end
            if (ledGreen === 1'b1 && gp !== 1'b1) ge++;
            if (ledRed === 1'b1 && rp !== 1'b1) re++;
            gp = ledGreen;
            rp = ledRed;
        end
    endtask : watch

    // bounded poll for the idle state
    task automatic wait_idle();
        for (int i = 0; i < 40; i++) begin
            reg_rd(REG_INFO, rd);
            if (rd[13:8] === ST_IDLE) return;
            tick_wait(100);
        end
        errors++;
        give_verdict();
    endtask : wait_idle

    initial begin
        void'($urandom(46));
        repeat (16) @(posedge clock);
        rstn <= 1'b1;
        @(posedge clock);
        chk_info(OFS_PAPER, 1'b0, ST_IDLE);
        n = $urandom_range(150, 40);
        fork
            i_ssm_operator.press(n);
            begin tick_wait(n / 2); check("lamp", 32'h0, lamp()); end
        join
        chk_info(OFS_PAPER, 1'b0, ST_IDLE);
        check("starts", 32'h0, starts);
        // teach pass then fail, irq on the way
        for (int k = 1; k >= 0; k--) begin
            s0 = starts;
            i_ssm_operator.press($urandom_range(900, 250));
            check("starts", s0 + 1, starts);
            chk_info(OFS_PAPER, 1'b0, ST_TEACH);
            watch(20);
            check("fast blink", 32'h1, 32'(ge > 1 && gl == 0));
            @(posedge clock);
            teachDone <= 1'b1;
            teachPass <= k[0];
            @(posedge clock);
            teachDone <= 1'b0;
            watch(250);
            check("code green", k ? 2 : 0, gl);
            check("code red", k ? 0 : 4, rl);
            reg_rd(REG_IRQ_STAT, rd);
            check("status", k ? 32'h1 : 32'h2, rd);
            check("irq", 32'h0, irq);
            wr(REG_IRQ_MASK, 32'h3f);
            check("irq", 32'h1, irq);
            wr(REG_IRQ_STAT, 32'h3f);
            check("irq", 32'h0, irq);
            wr(REG_IRQ_MASK, 32'h0);
        end
        i_ssm_operator.press($urandom_range(1400, 1100));
        chk_info(OFS_PAPER, 1'b0, ST_MAT);
        watch(50);
        check("paper colour", 32'h1, 32'(ge > 0 && re == 0));
        i_ssm_operator.press($urandom_range(100, 20));
        chk_info(OFS_METAL, 1'b1, ST_MAT);
        watch(50);
        check("metal colour", 32'h1, 32'(re > 0 && ge == 0));
        tick_wait(850);
        chk_info(OFS_METAL, 1'b1, ST_MAT);
        tick_wait(200);
        chk_info(OFS_METAL, 1'b1, ST_IDLE);
        i_ssm_operator.press($urandom_range(1900, 1600));
        watch(540);
        check("entry code", 32'd10, gl);
        i_ssm_operator.press($urandom_range(60, 20));
        ofs = step(OFS_METAL, 1'b1);
        watch(590);
        check("step code", {27'h0, ofs}, gl);
        for (int k = 0; k < 10; k++) begin
            i_ssm_operator.press($urandom_range(60, 20));
            ofs = step(ofs, 1'b1);
        end
        check("offset", {27'h0, ofs}, {27'h0, offsetVal});
        i_ssm_operator.press(300);
        ofs = step(ofs, 1'b0);
        check("offset", {27'h0, ofs}, {27'h0, offsetVal});
        wait_idle();
        // one long hold through every window
        fork
            i_ssm_operator.press(2100);
            begin
                tick_wait(100); check("lamp", 32'h0, lamp());
                tick_wait(400); check("lamp", 32'h2, lamp());
                tick_wait(650); watch(100); check("blink", 32'h1, 32'(ge > 1));
                tick_wait(450); check("lamp", 32'h0, lamp());
                tick_wait(350); check("lamp", 32'h2, lamp());
            end
        join
        watch(160);
        check("restore code", 32'h2, gl);
        chk_info(OFS_PAPER, 1'b0, ST_IDLE);
        // counter cleared, next short hold does nothing
        s0 = starts;
        i_ssm_operator.press(100);
        check("starts", s0, starts);
        chk_info(OFS_PAPER, 1'b0, ST_IDLE);
        // lock bit and unmapped place
        wr(REG_CTRL, 32'h1);
        reg_rd(REG_CTRL, rd);
        check("ctrl", 32'h1, rd);
        i_ssm_operator.press(300);
        check("starts", s0, starts);
        wr(REG_CTRL, 32'h0);
        wr(4'hf, $urandom);
        reg_rd(4'hf, rd);
        check("unmapped", 32'h0, rd);
        give_verdict();
    end
endmodule : ssm_setting_menu_tb

bind ssm_setting_menu ssm_menu_props i_ssm_menu_props (.clock(clock), .rstn(rstn),
    .teachStart(teachStart), .teachBusy(teachBusy), .labelMetal(labelMetal),
    .offsetVal(offsetVal), .ledGreen(ledGreen), .ledRed(ledRed), .regRead(regRead),
    .regRdata(regRdata));
